/* hdl/pcgc_map.svh */
// Purpose: Register offsets, field slices, reset values and counts
// Assumes: Included by its bare name wherever the names are needed
// Notes: Definitions only
`ifndef PCGC_MAP_SVH
`define PCGC_MAP_SVH

`define PCGC_ADDR_GAIN_ONE 4'h0
`define PCGC_ADDR_GAIN_TWO 4'h1
`define PCGC_ADDR_CTRL_ONE 4'h3
`define PCGC_ADDR_CTRL_TWO 4'h4

`define PCGC_RST_GAIN_ONE 8'h00
`define PCGC_RST_GAIN_TWO 8'h00
`define PCGC_RST_CTRL_ONE 8'h00
`define PCGC_RST_CTRL_TWO 8'h00

// Gain control one
`define PCGC_F_TXFG 2:0
`define PCGC_F_RXFG 5:3
`define PCGC_F_MIC 6
`define PCGC_F_EAR_LO 7
// Gain control two
`define PCGC_F_STG 2:0
`define PCGC_F_EAR_HI 4
// Codec control one
`define PCGC_F_RXSIL 0
`define PCGC_F_TXSIL 1
`define PCGC_F_PORTPD 2
`define PCGC_F_SPKPD 3
// Codec control two
`define PCGC_F_LAW 0
`define PCGC_F_CODING 1
`define PCGC_F_MODE 4:2
`define PCGC_MODE_BUS 3'h7
`define PCGC_STG_OFF 3'h0

// Microport command byte
`define PCGC_F_MP_READ 7
`define PCGC_F_MP_ADDR 3:0
`define PCGC_LAST_BIT 3'h7

// Code assignment
`define PCGC_MU_XOR 8'h7f
`define PCGC_A_XOR 8'h55
`define PCGC_SMAG_NEG_ZERO 8'h00

// Synchroniser lanes
`define PCGC_SY_W 8
`define PCGC_SY_CS 0
`define PCGC_SY_SCLK 1
`define PCGC_SY_MOSI 2
`define PCGC_SY_BCLK 3
`define PCGC_SY_STB 4
`define PCGC_SY_DIN 5
`define PCGC_SY_LAW 6
`define PCGC_SY_POR 7
`define PCGC_SY_IDLE 8'h81

// Timing
`define PCGC_CLK_NS 25
`define PCGC_POR_FILT_NS 100
`define PCGC_POR_FILT_CYC \
  ((`PCGC_POR_FILT_NS + `PCGC_CLK_NS - 1) / `PCGC_CLK_NS)

`endif

/* hdl/pcgc_pkg.sv */
// Purpose: Types shared by the codec port and its ports
// Assumes: Nothing
// Notes: Offsets and counts live in pcgc_map.svh
package pcgc_pkg;

  typedef struct packed {
    logic [2:0] tx_filter_gain;
    logic [2:0] rx_filter_gain;
    logic [2:0] sidetone_gain;
    logic sidetone_en;
    logic mic_amp_gain_sel;
    logic [1:0] earpiece_gain_sel;
    logic port_pwr_dn;
    logic spkr_pwr_dn;
  } pcgc_analog_t;

  typedef struct packed {
    logic a_law;
    logic coding_select;
    logic tx_silence;
    logic rx_silence;
    logic [2:0] port_mode_sel;
  } pcgc_coding_t;

  typedef enum logic [1:0] {
    MP_IDLE,
    MP_CMD,
    MP_DATA,
    MP_DONE
  } pcgc_mp_state_t;

endpackage : pcgc_pkg

/* hdl/pcgc_fifo.sv */
// Purpose: Sample FIFO between converter side and the serial port
// Assumes: One clock, synchronous active-high reset
// Notes: in_ready is registered
`timescale 1ns/1ps
module pcgc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : ptr_next

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
      count_q <= count_d;
      in_ready <= (count_d != CW'(DEPTH));
    end
  end

  chk_fifo_full_ready: assert property (@(posedge clk) disable iff (rst)
    (count_q == CW'(DEPTH)) |-> !in_ready)
    else $error("FIFO full but ready high");

endmodule : pcgc_fifo

/* hdl/pcgc_port.sv */
// Purpose: Strobed voice port, code assignment and gain registers
// Assumes: Pins are asynchronous to core_clk and pass two flip-flops
// Notes: Bit clock edges are found by sampling it with core_clk
//
// What this block does
// - Send 8-bit sample on bit-clock rise in slot
// - Data output three-state outside own slot
// - Capture 8-bit sample on bit-clock fall
// - Reset: sidetone off, gains 0 dB, mu-law
// - Transmit filter gain field, 0 to +7 dB
// - Receive filter gain field, 0 to -7 dB
// - Sidetone gain field, 3.32 dB steps
// - Sidetone enabled through its gain bits
// - A-law when register bit or pin high
// - Coding bit picks companded or sign-magnitude
// - Sign-magnitude code points
// - Mu-law code points
// - A-law code points
// - Microphone amplifier gain select bit
// - Earpiece gain select, 0/-6/-12 dB
// - Silence bits force negative-zero quiet code
// - Port mode field, all ones bus mode
// - Power-up reset active low, hysteresis filtered
`timescale 1ns/1ps
`include "pcgc_map.svh"
module pcgc_port #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic power_on_reset_n,
  input wire logic law_sel_pin,
  input wire logic bit_clk,
  input wire logic timeslot_strobe,
  input wire logic data_in,
  output logic data_out,
  output logic data_out_oe,
  input wire logic mp_cs_n,
  input wire logic mp_sclk,
  input wire logic mp_data_rx,
  output logic mp_data_tx,
  output logic mp_data_tx_oe,
  input wire logic [7:0] adc_code,
  input wire logic adc_valid,
  output logic adc_ready,
  output logic [7:0] dac_code,
  output logic dac_valid,
  output pcgc_pkg::pcgc_analog_t analog_cfg,
  output pcgc_pkg::pcgc_coding_t coding_cfg,
  output logic bus_mode_req
);
  import pcgc_pkg::*;

  logic [`PCGC_SY_W-1:0] sync1_q;
  logic [`PCGC_SY_W-1:0] sync2_q;
  logic por_ok_q;
  logic [2:0] por_cnt_q;
  logic rst_int;
  logic sclk_d_q;
  logic bclk_d_q;
  logic [7:0] gain_one_q;
  logic [7:0] gain_two_q;
  logic [7:0] ctrl_one_q;
  logic [7:0] ctrl_two_q;
  pcgc_mp_state_t mp_st_q;
  logic [2:0] mp_cnt_q;
  logic [7:0] mp_sh_q;
  logic [7:0] mp_cmd_q;
  logic [7:0] mp_rd_q;
  logic [7:0] mp_rd_word;
  logic slot_q;
  logic [2:0] tx_cnt_q;
  logic [7:0] tx_sh_q;
  logic [3:0] rx_cnt_q;
  logic [7:0] rx_sh_q;
  logic rx_done_q;
  logic cs_act;
  logic mp_rise;
  logic mp_fall;
  logic [7:0] mp_in_byte;
  logic mp_wr;
  logic lk_rise;
  logic lk_fall;
  logic frame_start;
  logic stb_s;
  logic fifo_valid;
  logic [7:0] fifo_data;
  pcgc_coding_t cfg_next;
  pcgc_analog_t ana_next;
  logic [7:0] tx_smag;
  logic [7:0] tx_code;

  // Maps between sign-magnitude and the selected code assignment
  function automatic logic [7:0] code_map(input logic [7:0] w,
                                          input logic a_law,
                                          input logic smag);
    if (smag) begin
      code_map = w;
    end else if (a_law) begin
      code_map = w ^ `PCGC_A_XOR;
    end else begin
      code_map = w ^ `PCGC_MU_XOR;
    end
  endfunction : code_map

  function automatic logic [7:0] reg_read(input logic [3:0] a,
                                          input logic [7:0] g1,
                                          input logic [7:0] g2,
                                          input logic [7:0] c1,
                                          input logic [7:0] c2);
    case (a)
      `PCGC_ADDR_GAIN_ONE: reg_read = g1;
      `PCGC_ADDR_GAIN_TWO: reg_read = g2;
      `PCGC_ADDR_CTRL_ONE: reg_read = c1;
      `PCGC_ADDR_CTRL_TWO: reg_read = c2;
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // Two-stage synchronisers for every pin
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_q <= `PCGC_SY_IDLE;
      sync2_q <= `PCGC_SY_IDLE;
    end else begin
      sync1_q <= {power_on_reset_n, law_sel_pin, data_in, timeslot_strobe,
                  bit_clk, mp_data_rx, mp_sclk, mp_cs_n};
      sync2_q <= sync1_q;
    end
  end

  // Hysteresis filter on the power-up reset pin
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      por_ok_q <= 1'b0;
      por_cnt_q <= 3'h0;
    end else if (sync2_q[`PCGC_SY_POR] == por_ok_q) begin
      por_cnt_q <= 3'h0;
    end else if (por_cnt_q == 3'(`PCGC_POR_FILT_CYC - 1)) begin
      por_ok_q <= ~por_ok_q;
      por_cnt_q <= 3'h0;
    end else begin
      por_cnt_q <= por_cnt_q + 3'h1;
    end
  end

  assign rst_int = sys_rst || !por_ok_q;

  always_ff @(posedge core_clk) begin
    if (rst_int) begin
      sclk_d_q <= 1'b0;
      bclk_d_q <= 1'b0;
    end else begin
      sclk_d_q <= sync2_q[`PCGC_SY_SCLK];
      bclk_d_q <= sync2_q[`PCGC_SY_BCLK];
    end
  end

  // Microport, SPI mode 0, command byte then data byte, MSB first
  assign cs_act = !sync2_q[`PCGC_SY_CS];
  assign mp_rise = cs_act && sync2_q[`PCGC_SY_SCLK] && !sclk_d_q;
  assign mp_fall = cs_act && !sync2_q[`PCGC_SY_SCLK] && sclk_d_q;
  assign mp_in_byte = {mp_sh_q[6:0], sync2_q[`PCGC_SY_MOSI]};
  assign mp_wr = (mp_st_q == MP_DATA) && mp_rise &&
                 (mp_cnt_q == `PCGC_LAST_BIT) &&
                 !mp_cmd_q[`PCGC_F_MP_READ];

  always_ff @(posedge core_clk) begin
    if (rst_int || !cs_act) begin
      mp_st_q <= MP_IDLE;
      mp_cnt_q <= 3'h0;
      mp_sh_q <= 8'h00;
      mp_cmd_q <= 8'h00;
    end else begin
      case (mp_st_q)
        MP_IDLE: begin
          mp_st_q <= MP_CMD;
        end
        MP_CMD, MP_DATA: begin
          if (mp_rise) begin
            mp_sh_q <= mp_in_byte;
            mp_cnt_q <= mp_cnt_q + 3'h1;
            if (mp_cnt_q == `PCGC_LAST_BIT) begin
              mp_st_q <= (mp_st_q == MP_CMD) ? MP_DATA : MP_DONE;
              if (mp_st_q == MP_CMD) begin
                mp_cmd_q <= mp_in_byte;
              end
            end
          end
        end
        MP_DONE: begin
          mp_st_q <= MP_DONE;
        end
        default: begin
          mp_st_q <= MP_IDLE;
        end
      endcase
    end
  end

  assign mp_rd_word = reg_read(mp_in_byte[`PCGC_F_MP_ADDR], gain_one_q,
                               gain_two_q, ctrl_one_q, ctrl_two_q);

  // MSB shown early, then each fall of the data byte presents the next bit
  always_ff @(posedge core_clk) begin
    if (rst_int || !cs_act) begin
      mp_data_tx <= 1'b0;
      mp_data_tx_oe <= 1'b0;
      mp_rd_q <= 8'h00;
    end else if (mp_st_q == MP_CMD && mp_rise &&
                 mp_cnt_q == `PCGC_LAST_BIT &&
                 mp_in_byte[`PCGC_F_MP_READ]) begin
      mp_rd_q <= mp_rd_word;
      mp_data_tx <= mp_rd_word[7];
      mp_data_tx_oe <= 1'b1;
    end else if (mp_st_q == MP_DATA && mp_fall && mp_data_tx_oe) begin
      mp_data_tx <= mp_rd_q[7];
      mp_rd_q <= {mp_rd_q[6:0], 1'b0};
    end
  end

  // Register file
  always_ff @(posedge core_clk) begin
    if (rst_int) begin
      gain_one_q <= `PCGC_RST_GAIN_ONE;
      gain_two_q <= `PCGC_RST_GAIN_TWO;
      ctrl_one_q <= `PCGC_RST_CTRL_ONE;
      ctrl_two_q <= `PCGC_RST_CTRL_TWO;
    end else if (mp_wr) begin
      case (mp_cmd_q[`PCGC_F_MP_ADDR])
        `PCGC_ADDR_GAIN_ONE: gain_one_q <= mp_in_byte;
        `PCGC_ADDR_GAIN_TWO: gain_two_q <= mp_in_byte;
        `PCGC_ADDR_CTRL_ONE: ctrl_one_q <= mp_in_byte;
        `PCGC_ADDR_CTRL_TWO: ctrl_two_q <= mp_in_byte;
        default: begin
        end
      endcase
    end
  end

  // Settings decoded from the registers and the law pin, applied at the frame boundary
  always_comb begin
    cfg_next.a_law = ctrl_two_q[`PCGC_F_LAW] ||
                     sync2_q[`PCGC_SY_LAW];
    cfg_next.coding_select = ctrl_two_q[`PCGC_F_CODING];
    cfg_next.tx_silence = ctrl_one_q[`PCGC_F_TXSIL];
    cfg_next.rx_silence = ctrl_one_q[`PCGC_F_RXSIL];
    cfg_next.port_mode_sel = ctrl_two_q[`PCGC_F_MODE];
    ana_next.tx_filter_gain = gain_one_q[`PCGC_F_TXFG];
    ana_next.rx_filter_gain = gain_one_q[`PCGC_F_RXFG];
    ana_next.sidetone_gain = gain_two_q[`PCGC_F_STG];
    ana_next.sidetone_en =
      (gain_two_q[`PCGC_F_STG] != `PCGC_STG_OFF);
    ana_next.mic_amp_gain_sel = gain_one_q[`PCGC_F_MIC];
    ana_next.earpiece_gain_sel = {gain_two_q[`PCGC_F_EAR_HI],
                                  gain_one_q[`PCGC_F_EAR_LO]};
    ana_next.port_pwr_dn = ctrl_one_q[`PCGC_F_PORTPD];
    ana_next.spkr_pwr_dn = ctrl_one_q[`PCGC_F_SPKPD];
  end

  always_ff @(posedge core_clk) begin
    if (rst_int) begin
      analog_cfg <= '0;
      coding_cfg <= '0;
      bus_mode_req <= 1'b0;
    end else if (frame_start) begin
      analog_cfg <= ana_next;
      coding_cfg <= cfg_next;
      bus_mode_req <= (cfg_next.port_mode_sel == `PCGC_MODE_BUS);
    end
  end

  // Serial voice port
  assign stb_s = sync2_q[`PCGC_SY_STB];
  assign lk_rise = sync2_q[`PCGC_SY_BCLK] && !bclk_d_q;
  assign lk_fall = !sync2_q[`PCGC_SY_BCLK] && bclk_d_q;
  assign frame_start = lk_rise && stb_s && !slot_q;
  assign tx_smag = (cfg_next.tx_silence || !fifo_valid) ?
                   `PCGC_SMAG_NEG_ZERO : fifo_data;
  assign tx_code = code_map(tx_smag, cfg_next.a_law,
                            cfg_next.coding_select);

  pcgc_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(core_clk),
    .rst(rst_int),
    .in_valid(adc_valid),
    .in_data(adc_code),
    .in_ready(adc_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(frame_start)
  );

  always_ff @(posedge core_clk) begin
    if (rst_int) begin
      slot_q <= 1'b0;
      tx_cnt_q <= 3'h0;
      tx_sh_q <= 8'h00;
      data_out <= 1'b0;
      data_out_oe <= 1'b0;
    end else if (lk_rise) begin
      if (!stb_s) begin
        slot_q <= 1'b0;
        data_out_oe <= 1'b0;
      end else if (!slot_q) begin
        slot_q <= 1'b1;
        tx_cnt_q <= 3'h0;
        tx_sh_q <= {tx_code[6:0], 1'b0};
        data_out <= tx_code[7];
        data_out_oe <= 1'b1;
      end else if (tx_cnt_q < `PCGC_LAST_BIT - 3'h1) begin
        tx_cnt_q <= tx_cnt_q + 3'h1;
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        data_out <= tx_sh_q[7];
      end else if (tx_cnt_q == `PCGC_LAST_BIT - 3'h1) begin
        tx_cnt_q <= `PCGC_LAST_BIT;
        data_out <= tx_sh_q[7];
      end else begin
        data_out_oe <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_int) begin
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (frame_start) begin
        rx_cnt_q <= 4'h0;
      end else if (lk_fall && slot_q && !rx_cnt_q[3]) begin
        rx_sh_q <= {rx_sh_q[6:0], sync2_q[`PCGC_SY_DIN]};
        rx_cnt_q <= rx_cnt_q + 4'h1;
        rx_done_q <= (rx_cnt_q == {1'b0, `PCGC_LAST_BIT});
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_int) begin
      dac_code <= `PCGC_SMAG_NEG_ZERO;
      dac_valid <= 1'b0;
    end else begin
      dac_valid <= rx_done_q;
      if (rx_done_q) begin
        dac_code <= coding_cfg.rx_silence ? `PCGC_SMAG_NEG_ZERO :
                    code_map(rx_sh_q, coding_cfg.a_law,
                             coding_cfg.coding_select);
      end
    end
  end

  chk_oe_release: assert property (
    @(posedge core_clk) disable iff (rst_int)
    (lk_rise && !stb_s) |=> !data_out_oe)
    else $error("Data output still driven outside slot");
  chk_first_bit: assert property (
    @(posedge core_clk) disable iff (rst_int)
    frame_start |=> data_out_oe && data_out == $past(tx_code[7]))
    else $error("First transmit bit wrong");
  chk_rx_eight: assert property (
    @(posedge core_clk) disable iff (rst_int)
    rx_done_q |-> rx_cnt_q == 4'h8 ##1 dac_valid)
    else $error("Receive word not eight bits");
  chk_reset_dflt: assert property (
    @(posedge core_clk)
    sys_rst |=> gain_one_q == `PCGC_RST_GAIN_ONE &&
    !analog_cfg.sidetone_en && coding_cfg == '0)
    else $error("Reset defaults wrong");
  chk_law_latch: assert property (
    @(posedge core_clk) disable iff (rst_int)
    frame_start |=> coding_cfg.a_law ==
    $past(ctrl_two_q[`PCGC_F_LAW] | sync2_q[`PCGC_SY_LAW]))
    else $error("Law not OR of bit and pin");
  chk_cfg_hold: assert property (
    @(posedge core_clk) disable iff (rst_int)
    !frame_start |=> $stable(coding_cfg) && $stable(analog_cfg))
    else $error("Settings changed mid frame");
  // Quiet code has a low first bit in every code assignment
  chk_tx_quiet: assert property (
    @(posedge core_clk) disable iff (rst_int)
    (frame_start && cfg_next.tx_silence) |=> !data_out)
    else $error("Quiet code not sent");
  chk_reg_write: assert property (
    @(posedge core_clk) disable iff (rst_int)
    (mp_wr && mp_cmd_q[`PCGC_F_MP_ADDR] == `PCGC_ADDR_GAIN_ONE)
    |=> gain_one_q == $past(mp_in_byte))
    else $error("Gain register write lost");
  chk_por_filter: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $rose(por_ok_q) |-> $past(sync2_q[`PCGC_SY_POR], 4))
    else $error("Reset release not filtered");

endmodule : pcgc_port

/* dv/pcgc_xcvr.sv */
// Purpose: Transceiver model on the strobed voice port
// Assumes: Bit clock of 200 ns, one pulse past the slot, still between frames
// Notes: Slots start at most once per 125 us
`timescale 1ns/1ps
module pcgc_xcvr (
  input wire logic data_out,
  input wire logic data_out_oe,
  output logic bit_clk,
  output logic timeslot_strobe,
  output logic data_in
);
  time next_q = 0;
  initial begin
    bit_clk = 1'b0;
    timeslot_strobe = 1'b0;
    data_in = 1'b0;
  end
  // A 5 MHz bit clock, sampled by the 40 MHz core clock
  task automatic frame(input logic [7:0] tx, output logic [7:0] seen,
                       output logic ok);
    if ($time < next_q) #(next_q - $time);
    next_q = $time + 125000;
    ok = 1'b1;
    seen = 8'h00;
    #13 timeslot_strobe = 1'b1;
    #100;
    for (int k = 0; k <= 8; k++) begin
      bit_clk = 1'b1;
      if (k > 0) begin
        seen[8-k] = data_out;
        ok = ok & (data_out_oe === 1'b1);
      end
      // Released line shows the inverse of its last bit
      data_in = (k < 8) ? tx[7-k] : ~data_in;
      #100 bit_clk = 1'b0;
      #50;
      if (k == 7) timeslot_strobe = 1'b0;
      #50;
    end
  endtask : frame
endmodule : pcgc_xcvr

/* dv/test_pcgc_port.sv */
// Purpose: Self-checking bench for the strobed voice port
// Assumes: Transceiver model on the link, microport driven here
// Notes: Random data from an LFSR that starts at 38
`timescale 1ns/1ps
module test_pcgc_port;
  import pcgc_pkg::*;
  localparam int DEPTH = 4;
  localparam logic [7:0] CORNER [4] = '{8'hff, 8'h80, 8'h00, 8'h7f};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic power_on_reset_n = 1'b0;
  logic law_sel_pin = 1'b0;
  logic mp_cs_n = 1'b1;
  logic mp_sclk = 1'b0;
  logic mp_data_rx = 1'b0;
  logic [7:0] adc_code = 8'h00;
  logic adc_valid = 1'b0;
  logic bit_clk, timeslot_strobe, data_in, data_out, data_out_oe;
  logic mp_data_tx, mp_data_tx_oe, adc_ready, dac_valid, bus_mode_req;
  logic [7:0] dac_code, dac_seen, seed, rd, g1, g2, pg1, pg2, smp;
  logic [7:0] fq [DEPTH];
  logic cur_a, cur_c, cur_rs, okx;
  pcgc_analog_t analog_cfg;
  pcgc_coding_t coding_cfg;
  int n_errors = 0;
  int n_compared = 0;
  int n_dac = 0;

  pcgc_port #(.FIFO_DEPTH(DEPTH)) dut (.core_clk(core_clk),
    .sys_rst(sys_rst), .power_on_reset_n(power_on_reset_n),
    .law_sel_pin(law_sel_pin), .bit_clk(bit_clk),
    .timeslot_strobe(timeslot_strobe), .data_in(data_in),
    .data_out(data_out), .data_out_oe(data_out_oe), .mp_cs_n(mp_cs_n),
    .mp_sclk(mp_sclk), .mp_data_rx(mp_data_rx), .mp_data_tx(mp_data_tx),
    .mp_data_tx_oe(mp_data_tx_oe), .adc_code(adc_code),
    .adc_valid(adc_valid), .adc_ready(adc_ready), .dac_code(dac_code),
    .dac_valid(dac_valid), .analog_cfg(analog_cfg),
    .coding_cfg(coding_cfg), .bus_mode_req(bus_mode_req));
  pcgc_xcvr xcvr (.data_out(data_out), .data_out_oe(data_out_oe),
    .bit_clk(bit_clk), .timeslot_strobe(timeslot_strobe),
    .data_in(data_in));

  always #12.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (dac_valid === 1'b1) begin
      dac_seen <= dac_code;
      n_dac <= n_dac + 1;
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic logic [7:0] enc(input logic [7:0] s, input logic a,
                                     input logic c);
    return c ? s : (a ? (s ^ 8'h55) : (s ^ 8'h7f));
  endfunction : enc

  function automatic pcgc_analog_t an(input logic [7:0] a,
                                      input logic [7:0] b);
    pcgc_analog_t r;
    r.tx_filter_gain = a[2:0];
    r.rx_filter_gain = a[5:3];
    r.sidetone_gain = b[2:0];
    r.sidetone_en = (b[2:0] != 3'h0);
    r.mic_amp_gain_sel = a[6];
    r.earpiece_gain_sel = {b[4], a[7]};
    r.port_pwr_dn = 1'b0;
    r.spkr_pwr_dn = 1'b0;
    return r;
  endfunction : an

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // Mode 0 access: 16 clocks, MSB first, read bits taken at each rise
  task automatic mp(input logic [15:0] w);
    rd = 8'h00;
    mp_cs_n <= 1'b0;
    cyc(8);
    for (int i = 15; i >= 0; i--) begin
      mp_data_rx <= w[i];
      cyc(8);
      mp_sclk <= 1'b1;
      if (i < 8) rd[i] = mp_data_tx;
      cyc(8);
      mp_sclk <= 1'b0;
    end
    cyc(8);
    mp_cs_n <= 1'b1;
    cyc(12);
  endtask : mp

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    mp({4'h0, a, d});
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    mp({4'h8, a, 8'h00});
    check($sformatf("reg %h", a), {8'h00, rd}, {8'h00, e});
    check("mp oe idle", {15'h0, mp_data_tx_oe}, 16'h0);
  endtask : rdchk

  task automatic push(input logic [7:0] b);
    adc_code <= b;
    adc_valid <= 1'b1;
    do @(posedge core_clk); while (adc_ready !== 1'b1);
    adc_valid <= 1'b0;
    @(posedge core_clk);
  endtask : push

  task automatic run_frame(input logic [7:0] tx);
    logic [7:0] rx;
    logic [7:0] seen;
    logic ok;
    int nd;
    logic [7:0] ex;
    seed = lfsr(seed);
    rx = seed;
    nd = n_dac;
    xcvr.frame(enc(rx, cur_a, cur_c), seen, ok);
    cyc(16);
    ex = enc(tx, cur_a, cur_c);
    check("tx code", {8'h00, seen}, {8'h00, ex});
    check("oe slot", {15'h0, ok}, 16'h1);
    check("oe idle", {15'h0, data_out_oe}, 16'h0);
    ex = cur_rs ? 8'h00 : rx;
    check("rx code", {8'h00, dac_seen}, {8'h00, ex});
    check("rx count", {15'h0, n_dac == nd + 1}, 16'h1);
  endtask : run_frame

  initial begin
    #2500000;
    n_errors++;
    $display("BAD watchdog expected end seen hang");
    close_out();
  end

  initial begin
    seed = 8'h26;
    {pg1, pg2, cur_a, cur_c, cur_rs} = '0;
    cyc(3);
    sys_rst <= 1'b0;
    cyc(5);
    power_on_reset_n <= 1'b1;
    cyc(12);
    check("analog rst", {1'b0, analog_cfg}, 16'h0);
    check("coding rst", {9'h0, coding_cfg}, 16'h0);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      g1 = seed;
      seed = lfsr(seed);
      g2 = seed;
      smp = (i < 4) ? CORNER[i] : lfsr(seed);
      wr(4'h0, g1);
      wr(4'h1, g2);
      wr(4'h4, {6'h00, i[2], i[1]});
      law_sel_pin <= i[0];
      check("gain held", {1'b0, analog_cfg}, {1'b0, an(pg1, pg2)});
      cur_c = i[2];
      cur_a = i[1] | i[0];
      push(smp);
      run_frame(smp);
      check("gains", {1'b0, analog_cfg}, {1'b0, an(g1, g2)});
      check("sidetone", {13'h0, analog_cfg.sidetone_gain},
            {13'h0, g2[2:0]});
      check("amp sel", {1'b0, analog_cfg}, {1'b0, an(g1, g2)});
      check("law", 16'(coding_cfg.a_law), 16'(cur_a));
      check("coding", 16'(coding_cfg.coding_select), 16'(cur_c));
      pg1 = g1;
      pg2 = g2;
    end
    wr(4'h2, 8'hff);
    rdchk(4'h0, pg1);
    rdchk(4'h1, pg2);
    rdchk(4'h4, 8'h03);
    rdchk(4'h2, 8'h00);
    $display("mode test done");
    wr(4'h3, 8'h03);
    cur_rs = 1'b1;
    push(8'h5a);
    run_frame(8'h00);
    rdchk(4'h3, 8'h03);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h00);
    law_sel_pin <= 1'b0;
    {cur_a, cur_c, cur_rs} = 3'h0;
    $display("silence test done");
    for (int k = 0; k < DEPTH; k++) begin
      seed = lfsr(seed);
      fq[k] = seed;
      push(seed);
    end
    cyc(2);
    check("fifo full", {15'h0, adc_ready}, 16'h0);
    adc_code <= 8'h11;
    adc_valid <= 1'b1;
    cyc(3);
    adc_valid <= 1'b0;
    for (int k = 0; k < DEPTH; k++) run_frame(fq[k]);
    run_frame(8'h00);
    $display("fifo test done");
    wr(4'h4, 8'h1c);
    xcvr.frame(8'h00, rd, okx);
    cyc(16);
    check("bus mode", {15'h0, bus_mode_req}, 16'h1);
    power_on_reset_n <= 1'b0;
    cyc(10);
    power_on_reset_n <= 1'b1;
    cyc(12);
    check("por analog", {1'b0, analog_cfg}, 16'h0);
    check("por mode", {8'h0, bus_mode_req, coding_cfg}, 16'h0);
    rdchk(4'h0, 8'h00);
    $display("power reset test done");
    close_out();
  end
endmodule : test_pcgc_port
